// File: logic/sar_readout.sv
// Purpose: serial readout sequencer of a 10-bit successive-approximation converter
// Assumes: host drives serial clock in mode 0,0 or 1,1 and samples on rising edges
// Notes:   conversion is modelled by latching a digital code at the end of sampling
//
// Notes on behaviour
// - sampling starts first rising edge after select falls
// - held sample becomes 10-bit serial result
// - select low at power-up needs high-then-low first
// - second falling edge ends sample, drives null
// - next ten clocks send result MSB first
// - output changes only on serial clock falling edges
// - MSB appears on third falling edge
// - output high impedance for first two clocks
// - further clocks repeat result LSB first
// - bit zero shared, repeat resumes at bit one
// - afterwards zeros while select stays low
// - raising select ends transfer at any time
// - one result bit per received serial clock
// - code saturates at 000h and 3FFh
// - code is unsigned straight binary of input
// - select high ends conversion, enters standby
`default_nettype none
module sar_readout
  import sar_pkg::*;
(
  input  wire logic                      i_clock,               // system clock 200 MHz
  input  wire logic                      i_rst,                 // async reset, high
  input  wire logic                      i_select_shutdown_n,   // select/shutdown pin, low active
  input  wire logic                      i_sclk,                // serial clock pin from host
  input  wire logic signed [RESULT_W:0]  i_analog_code,         // differential input scaled to codes
  output logic                           o_dout,                // serial data out level
  output logic                           o_dout_oe_n,           // low while data out is driven
  output logic                           o_standby              // high while in low-power standby
);
  sar_state_t state_ff;
  sar_state_t nxt_state;
  logic [4:0]  edge_cnt_ff;
  logic [4:0]  nxt_edge_cnt;
  logic [9:0]  sample_ff;
  logic [9:0]  nxt_sample;
  logic        dout_ff;
  logic        nxt_dout;
  logic        oe_n_ff;
  logic        nxt_oe_n;
  logic        armed_ff;
  logic        nxt_armed;
  logic        sclk_d_ff;
  logic        sel_n_s;
  logic        sclk_s;
  logic        sclk_rise;
  logic        sclk_fall;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // select resets low so a low pin at power-up stays locked until it goes high
  sar_sync #(.RST_VAL(1'b0)) u_sel_sync
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_d     (i_select_shutdown_n),
    .o_q     (sel_n_s)
  );

  sar_sync #(.RST_VAL(1'b0)) u_sclk_sync
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_d     (i_sclk),
    .o_q     (sclk_s)
  );

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      sclk_d_ff <= 1'b0;
    else
      sclk_d_ff <= sclk_s;
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  // ----------------------------------------------------------------
  // conversion model
  // ----------------------------------------------------------------
  function automatic logic [9:0] sar_saturate(input logic signed [RESULT_W:0] code);
    if (code <= 0)
      sar_saturate = CODE_ZERO;
    else if (code >= $signed({1'b0, CODE_FULL}))
      sar_saturate = CODE_FULL;
    else
      sar_saturate = code[9:0];
  endfunction

  // bit index on the data line for a given falling-edge count
  function automatic logic sar_bit(input logic [9:0] res, input logic [4:0] cnt);
    logic [4:0] idx;
    idx = 5'h00;
    sar_bit = 1'b0;
    if (cnt > NULL_EDGE && cnt <= MSB_FIRST_END)
    begin
      idx = MSB_FIRST_END - cnt;
      sar_bit = res[idx[3:0]];
    end
    else if (cnt > MSB_FIRST_END && cnt <= LSB_FIRST_END)
    begin
      idx = cnt - MSB_FIRST_END;
      sar_bit = res[idx[3:0]];
    end
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_sample   = sample_ff;
    nxt_dout     = dout_ff;
    nxt_oe_n     = oe_n_ff;
    nxt_armed    = armed_ff;
    unique case (state_ff)
      SAR_LOCKED:
      begin
        if (sel_n_s)
          nxt_state = SAR_IDLE;
      end
      SAR_IDLE:
      begin
        nxt_oe_n     = 1'b1;
        nxt_edge_cnt = EDGE_CNT_RST;
        nxt_armed    = 1'b0;
        if (!sel_n_s)
          nxt_state = SAR_ACQUIRE;
      end
      SAR_ACQUIRE:
      begin
        // first rising edge opens the sample; input tracked until second fall
        if (sclk_rise)
          nxt_armed = 1'b1;
        // clock idling high gives a fall before any rise: it must not count
        if (sclk_fall && armed_ff)
        begin
          nxt_edge_cnt = edge_cnt_ff + 5'h01;
          if (edge_cnt_ff + 5'h01 == NULL_EDGE)
          begin
            nxt_sample = sar_saturate(i_analog_code);
            nxt_dout   = 1'b0;
            nxt_oe_n   = 1'b0;
            nxt_state  = SAR_SHIFT;
          end
        end
      end
      SAR_SHIFT:
      begin
        if (sclk_fall)
        begin
          if (edge_cnt_ff != EDGE_CNT_MAX)
            nxt_edge_cnt = edge_cnt_ff + 5'h01;
          nxt_dout = sar_bit(sample_ff, edge_cnt_ff + 5'h01);
        end
      end
    endcase
    if (sel_n_s && state_ff != SAR_LOCKED)
    begin
      nxt_state = SAR_IDLE;
      nxt_oe_n  = 1'b1;
      nxt_armed = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff    <= SAR_LOCKED;
      edge_cnt_ff <= EDGE_CNT_RST;
      sample_ff   <= SAMPLE_RST;
      dout_ff     <= DOUT_RST;
      oe_n_ff     <= OE_N_RST;
      armed_ff    <= ARMED_RST;
    end
    else
    begin
      state_ff    <= nxt_state;
      edge_cnt_ff <= nxt_edge_cnt;
      sample_ff   <= nxt_sample;
      dout_ff     <= nxt_dout;
      oe_n_ff     <= nxt_oe_n;
      armed_ff    <= nxt_armed;
    end
  end

  assign o_dout      = dout_ff;
  assign o_dout_oe_n = oe_n_ff;
  assign o_standby   = (state_ff == SAR_IDLE) || (state_ff == SAR_LOCKED);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence sar_null_edge_s;
    state_ff == SAR_ACQUIRE && sclk_fall && edge_cnt_ff == 5'h01 && !sel_n_s;
  endsequence

  hiz_before_null_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_ACQUIRE) |-> oe_n_ff) else $error("data out driven before null bit");
  null_bit_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
    sar_null_edge_s |=> (!o_dout && !o_dout_oe_n && state_ff == SAR_SHIFT))
    else $error("null bit not driven low");
  msb_third_fall_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_SHIFT && sclk_fall && edge_cnt_ff == NULL_EDGE && !sel_n_s)
    |=> (o_dout == sample_ff[9])) else $error("msb not on third falling edge");
  change_on_fall_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_SHIFT && !sclk_fall && !sel_n_s) |=> $stable(o_dout))
    else $error("data out changed off a falling edge");
  lsb_repeat_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_SHIFT && sclk_fall && edge_cnt_ff == MSB_FIRST_END && !sel_n_s)
    |=> (o_dout == sample_ff[1])) else $error("lsb repeat not resumed at bit one");
  zeros_after_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_SHIFT && sclk_fall && edge_cnt_ff >= LSB_FIRST_END && !sel_n_s)
    |=> !o_dout) else $error("trailing bits not zero");
  select_release_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (sel_n_s && state_ff != SAR_LOCKED) |=> (o_dout_oe_n && state_ff == SAR_IDLE))
    else $error("select high did not end transfer");
  powerup_lock_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_LOCKED && !sel_n_s) |=> state_ff == SAR_LOCKED)
    else $error("transfer began without select rising first");
  acquire_arm_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_ACQUIRE && !armed_ff && !sel_n_s) |=> edge_cnt_ff == EDGE_CNT_RST)
    else $error("fall counted before first rise");
  saturate_code_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (sar_null_edge_s and (i_analog_code <= 0)) |=> sample_ff == CODE_ZERO)
    else $error("code did not saturate low");
  one_bit_edge_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_ff == SAR_SHIFT && sclk_fall && !sel_n_s && edge_cnt_ff != EDGE_CNT_MAX)
    |=> edge_cnt_ff == $past(edge_cnt_ff) + 5'h01) else $error("bit count not one per clock");
endmodule
`default_nettype wire

// File: logic/sar_pkg.sv
// Purpose: constants for the serial readout sequencer of a 10-bit SAR converter
// Assumes: serial clock and select are sampled by a 200 MHz system clock
// Notes:   one package shared by the sequencer and its synchroniser
`default_nettype none
package sar_pkg;
  localparam int unsigned RESULT_W      = 10;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SYNC_STAGES   = 2;
  // cycle positions counted in falling edges after the first rising edge once select falls
  localparam logic [4:0]  NULL_EDGE     = 5'h02;
  localparam logic [4:0]  MSB_FIRST_END = 5'h0C;
  localparam logic [4:0]  LSB_FIRST_END = 5'h15;
  localparam logic [4:0]  EDGE_CNT_MAX  = 5'h1F;
  localparam logic [9:0]  CODE_ZERO     = 10'h000;
  localparam logic [9:0]  CODE_FULL     = 10'h3FF;
  localparam logic [4:0]  EDGE_CNT_RST  = 5'h00;
  localparam logic [9:0]  SAMPLE_RST    = 10'h000;
  localparam logic        DOUT_RST      = 1'b0;
  localparam logic        OE_N_RST      = 1'b1;
  localparam logic        ARMED_RST     = 1'b0;
  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_LOCKED,
    SAR_ACQUIRE,
    SAR_SHIFT
  } sar_state_t;
endpackage
`default_nettype wire

// File: logic/sar_sync.sv
// Purpose: two-flop synchroniser for pins entering the system clock domain
// Assumes: i_d is asynchronous to i_clock
// Notes:   reset value is a port-free constant
`default_nettype none
module sar_sync
  import sar_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)(
  input  wire logic i_clock,   // system clock
  input  wire logic i_rst,     // async reset, high
  input  wire logic i_d,       // asynchronous level
  output logic      o_q        // synchronised level
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb
  begin
    nxt_meta = i_d;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign o_q = sync_ff;
endmodule
`default_nettype wire

// File: test/sar_host_model.sv
// Purpose: host master model, modes 0,0 and 1,1
// Assumes: runs on the system clock
// Notes:   bit k of o_bits is the capture at rise k
`default_nettype none
module sar_host_model
(
  input  wire logic        i_clock, // system clock
  input  wire logic        i_go,    // start a frame
  input  wire logic [5:0]  i_nclk,  // clocks per frame
  input  wire logic [7:0]  i_half,  // half period less one, cycles
  input  wire logic        i_idle,  // idle select level
  input  wire logic        i_cpol,  // idle clock level
  input  wire logic        i_sdo,   // data pin level
  output logic             o_sel_n, // select pin
  output logic             o_sclk,  // serial clock pin
  output logic             o_busy,  // frame running
  output logic [31:0]      o_bits   // captured bits
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] tmr = 9'h000;
  logic [5:0] n   = 6'h00;
  initial {o_sel_n, o_sclk, o_busy, o_bits} = '0;
  always @(posedge i_clock)
  begin
    if (!o_busy)
    begin
      o_sel_n <= i_go ? 1'b0 : i_idle;
      o_sclk <= i_cpol;
      o_busy <= i_go;
      tmr <= {1'b0, i_half};
      n <= 6'h00;
    end
    else if (tmr != 9'h000)
      tmr <= tmr - 9'h001;
    else if (n == 6'h3F)
      o_busy <= 1'b0;
    else if (o_sclk && !(i_cpol && n == i_nclk))
    begin
      // idling high: frame opens with a fall and ends on the last rise
      o_sclk <= 1'b0;
      tmr <= {1'b0, i_half};
    end
    else if (n != i_nclk)
    begin
      o_sclk <= 1'b1;
      o_bits[n + 6'h01] <= i_sdo;
      n <= n + 6'h01;
      tmr <= {1'b0, i_half};
    end
    else
    begin
      // clock stays at its idle level outside frames
      o_sel_n <= i_idle;
      tmr <= {i_half, 1'b0};
      n <= 6'h3F;
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for the readout sequencer
// Assumes: host model clocks at 170 ns
// Notes:   one task per scenario
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sar_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic signed [RESULT_W:0] code = '0;
  logic go = 1'b0;
  logic idle = 1'b0;
  logic cpol = 1'b0;
  logic [5:0] nclk = 6'h00;
  logic [7:0] half = 8'h10;
  logic sel_n, sclk, busy, dout, oe_n, standby;
  logic [31:0] bits;
  wire logic sdo = oe_n ? 1'bz : dout;
  int failures = 0;
  int check_count = 0;
  always #2.5 i_clock = ~i_clock;
  sar_readout dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_select_shutdown_n(sel_n),
    .i_sclk(sclk), .i_analog_code(code), .o_dout(dout), .o_dout_oe_n(oe_n), .o_standby(standby));
  sar_host_model host_u (.i_clock(i_clock), .i_go(go), .i_nclk(nclk), .i_half(half),
    .i_idle(idle), .i_cpol(cpol), .i_sdo(sdo), .o_sel_n(sel_n), .o_sclk(sclk), .o_busy(busy),
    .o_bits(bits));
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(string what, logic exp, logic got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %b got %b", what, exp, got);
    end
  endtask
  function automatic logic exp_bit(int k, logic signed [RESULT_W:0] c);
    logic [9:0] v;
    v = (c < 0) ? CODE_ZERO : c[9:0];
    if (k <= 2) return 1'bz;
    if (k == 3) return 1'b0;
    if (k <= 13) return v[13 - k];
    if (k <= 22) return v[k - 13];
    return 1'b0;
  endfunction
  task automatic frame(logic signed [RESULT_W:0] c, int n, int h);
    @(posedge i_clock);
    code <= c;
    nclk <= 6'(n);
    half <= 8'(h);
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    @(negedge i_clock);
    for (int t = 0; busy && t < 40000; t++)
      @(negedge i_clock);
    if (busy)
    begin
      $display("MISMATCH frame_end exp 0 got 1");
      failures++;
      end_sim();
    end
  endtask
  task automatic check_bits(logic signed [RESULT_W:0] c, int n);
    for (int k = 1; k <= n; k++)
      check($sformatf("bit%0d", k), exp_bit(k, c), bits[k]);
  endtask
  task automatic t_lock();
    frame(11'sh155, 14, 16);
    for (int k = 1; k <= 14; k++)
      check("locked_bit", 1'bz, bits[k]);
    check("locked_standby", 1'b1, standby);
  endtask
  task automatic t_full();
    @(posedge i_clock);
    idle <= 1'b1;
    repeat (20) @(negedge i_clock);
    frame(11'sh2D3, 26, 16);
    check_bits(11'sh2D3, 26);
    check("oe_n_after", 1'b1, oe_n);
    check("standby_after", 1'b1, standby);
  endtask
  task automatic t_partial();
    frame(11'sh0F0, 8, 16);
    check_bits(11'sh0F0, 8);
    check("oe_n_early", 1'b1, oe_n);
    frame(11'sh30F, 13, 16);
    check_bits(11'sh30F, 13);
  endtask
  task automatic t_sat();
    logic signed [RESULT_W:0] tbl [4] = '{11'sh7FF, 11'sh400, 11'sh000, 11'sh3FF};
    foreach (tbl[i])
    begin
      frame(tbl[i], 13, 16);
      check_bits(tbl[i], 13);
    end
  endtask
  // clock idling high: leading fall must not start the count
  task automatic t_mode11();
    @(posedge i_clock);
    cpol <= 1'b1;
    repeat (8) @(posedge i_clock);
    frame(11'sh1A5, 24, 16);
    check_bits(11'sh1A5, 24);
    check("oe_n_mode11", 1'b1, oe_n);
  endtask
  // data may only move shortly after a clock fall
  logic p_sclk = 1'b0;
  logic p_dout = 1'b0;
  logic p_oe = 1'b1;
  int since = 0;
  always @(posedge i_clock)
  begin
    since <= (p_sclk && !sclk) ? 0 : since + 1;
    if (!p_oe && !oe_n && dout !== p_dout && since > 6)
    begin
      failures++;
      $display("MISMATCH dout_edge exp %b got %b", p_dout, dout);
    end
    p_sclk <= sclk;
    p_dout <= dout;
    p_oe <= oe_n;
  end
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    t_lock();
    t_full();
    t_partial();
    t_sat();
    t_mode11();
    end_sim();
  end
endmodule
`default_nettype wire
